// >>> rtl/dcrb_defines.vh
// Purpose: Shared constants of the drive command register bank
// Assumes: Word-addressed 16-bit command registers
// Notes:   Definitions only; included by bare name
`ifndef DCRB_DEFINES_VH
`define DCRB_DEFINES_VH

// ------------------------------------------------------------
// Register word addresses
// ------------------------------------------------------------
`define DCRB_ADDR_RSVD0      16'h0000
`define DCRB_ADDR_OPER       16'h0001
`define DCRB_ADDR_SPEED      16'h0002
`define DCRB_ADDR_GAIN       16'h0003
`define DCRB_ADDR_RSVD4      16'h0004
`define DCRB_ADDR_RSVD5      16'h0005
`define DCRB_ADDR_SETPT      16'h0006
`define DCRB_ADDR_AOUT       16'h0007
`define DCRB_ADDR_RSVD8      16'h0008

// ------------------------------------------------------------
// Operation word field positions
// ------------------------------------------------------------
`define DCRB_BIT_RUN0        0
`define DCRB_BIT_RUN1        1
`define DCRB_BIT_EXTF        2
`define DCRB_BIT_FRST        3
`define DCRB_BIT_MF_LO       4
`define DCRB_BIT_MF_HI       10
`define DCRB_OPER_MASK       16'h07FF

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define DCRB_RST_OPER        16'h0000
`define DCRB_RST_SPEED       16'h0000
`define DCRB_RST_GAIN        16'h0000
`define DCRB_RST_SETPT       16'h0000
`define DCRB_RST_AOUT        16'h0000

// ------------------------------------------------------------
// Selection codes and scaling
// ------------------------------------------------------------
`define DCRB_FN_NET_REF      8'h28
`define DCRB_FN_NET_CTRL     8'h29
`define DCRB_AOUT_FULL       16'h4000
`define DCRB_AOUT_SHIFT      14

// ------------------------------------------------------------
// Option fault codes
// ------------------------------------------------------------
`define DCRB_OFC_INCOMPAT    8'h00
`define DCRB_OFC_CONNECTOR   8'h01
`define DCRB_OFC_SELFTEST    8'h03
`define DCRB_OFC_FLASH       8'h04

`endif

// >>> rtl/dcrb_analog_scale.v
// Purpose: Linear scaling of the analog output level to a DAC code
// Assumes: Level is signed 16-bit, full scale at 4000 hex
// Notes:   Negative clamps to zero, above full scale clamps high
`timescale 1ns/100ps
`include "dcrb_defines.vh"

module dcrb_analog_scale #(
  parameter DAC_W = 12                    // DAC code width
) (
  input  wire             mclk_in,        // System clock
  input  wire             srst_in,        // Sync reset, high
  input  wire [15:0]      level_in,       // Register value
  output reg  [DAC_W-1:0] code_out        // DAC code
);

  // ------------------------------------------------------------
  // Scaling arithmetic
  // ------------------------------------------------------------
  localparam [DAC_W-1:0] FULL_CODE = {DAC_W{1'b1}}; // Top code

  wire [DAC_W+15:0] product;              // Level times top code
  wire [DAC_W+15:0] scaled;               // Product over 4000 hex

  assign product = level_in * FULL_CODE;
  assign scaled  = product >> `DCRB_AOUT_SHIFT;

  // Registered so the DAC sees no glitches
  always @(posedge mclk_in) begin
    if (srst_in) begin
      code_out <= {DAC_W{1'b0}};
    end else if (level_in[15]) begin
      // Negative request: no negative range on the terminal
      code_out <= {DAC_W{1'b0}};
    end else if (level_in >= `DCRB_AOUT_FULL) begin
      code_out <= FULL_CODE;
    end else begin
      code_out <= scaled[DAC_W-1:0];
    end
  end

endmodule // dcrb_analog_scale

// >>> rtl/dcrb_fault_monitor.v
// Purpose: Latches option card faults and option link loss
// Assumes: Status inputs are levels synchronous to mclk_in
// Notes:   Latched faults clear on a fault reset pulse; set wins
`timescale 1ns/100ps
`include "dcrb_defines.vh"

module dcrb_fault_monitor (
  input  wire       mclk_in,              // System clock
  input  wire       srst_in,              // Sync reset, high
  input  wire       incompat_in,          // Wrong option type
  input  wire       connector_in,         // Bad connector link
  input  wire       selftest_in,          // Self-test failed
  input  wire       flash_mode_in,        // Card in flash mode
  input  wire       link_up_in,           // Option link alive
  input  wire       assigned_in,          // Run and ref on option
  input  wire       clear_in,             // Fault reset pulse
  output reg  [3:0] flags_out,            // 00,01,03,04 latched
  output reg        loss_out,             // Link loss latched
  output reg  [7:0] code_out,             // Highest priority code
  output reg        any_out               // Any option fault
);

  // ------------------------------------------------------------
  // Detection
  // ------------------------------------------------------------
  reg        seen_link;                   // Link was once up
  wire [3:0] raw;                         // Live fault causes
  wire       loss_now;                    // Loss condition now
  wire [3:0] next_flags;                  // Set wins over clear

  assign raw = {flash_mode_in, selftest_in, connector_in,
                incompat_in};
  // Loss counts only once the link came up and only when
  // both run and reference are owned by the option
  assign loss_now = seen_link & ~link_up_in & assigned_in;
  assign next_flags = (flags_out & {4{~clear_in}}) | raw;

  // Latches and priority encode
  always @(posedge mclk_in) begin
    if (srst_in) begin
      seen_link <= 1'b0;
      flags_out <= 4'h0;
      loss_out  <= 1'b0;
      code_out  <= 8'h00;
      any_out   <= 1'b0;
    end else begin
      seen_link <= seen_link | link_up_in;
      flags_out <= next_flags;
      loss_out  <= (loss_out & ~clear_in) | loss_now;
      any_out   <= |next_flags;
      // Lowest code reported first
      if (next_flags[0]) begin
        code_out <= `DCRB_OFC_INCOMPAT;
      end else if (next_flags[1]) begin
        code_out <= `DCRB_OFC_CONNECTOR;
      end else if (next_flags[2]) begin
        code_out <= `DCRB_OFC_SELFTEST;
      end else if (next_flags[3]) begin
        code_out <= `DCRB_OFC_FLASH;
      end else begin
        code_out <= 8'h00;
      end
    end
  end

endmodule // dcrb_fault_monitor

// >>> rtl/dcrb_command_bank.v
// Purpose: Command register bank of a motor drive option port
// Assumes: One word access per request, synchronous inputs
// Notes:   Reserved words read zero and ignore writes
`timescale 1ns/100ps
`include "dcrb_defines.vh"

// Overview of operation
// - Command registers are readable and writable
// - Style 0: bit 0 forward run
// - Style 0: bit 1 reverse run
// - Style 1: bit 0 run or stop
// - Style 1: bit 1 selects reverse direction
// - Bit 2 raises external fault, follows bit
// - Bits 4-A inputs; input1 code 40 reference
// - Input 2 code 41 selects network control
// - Speed reference in selected display units
// - Gain applied only in volts-per-hertz control
// - Setpoint signed, hundredths of a percent
// - Analog level 4000 hex equals ten volts
// - Incompatible option raises fault code 00
// - Bad connector raises fault code 01
// - Option self-test error raises code 03
// - Option flash mode raises code 04
// - Link loss only when option owns control
module dcrb_command_bank #(
  parameter        DAC_W      = 12,         // Analog DAC width
  parameter [15:0] UNITY_GAIN = 16'h0064    // Gain outside V/f
) (
  input  wire             mclk_in,          // System clock
  input  wire             srst_in,          // Sync reset, high
  // Register port
  input  wire [15:0]      reg_addr_in,      // Word address
  input  wire             reg_wr_in,        // Write strobe
  input  wire             reg_rd_in,        // Read strobe
  input  wire [15:0]      reg_wdata_in,     // Write data
  output reg  [15:0]      reg_rdata_out,    // Read data
  output reg              reg_ack_out,      // Access done
  // Drive parameters
  input  wire             run_command_style_select_in, // Style
  input  wire [7:0]       input1_function_select_in,   // In 1 fn
  input  wire [7:0]       input2_function_select_in,   // In 2 fn
  input  wire [2:0]       speed_unit_select_in,        // Units
  input  wire             vf_control_mode_in,          // V/f on
  // Option card status
  input  wire             option_incompatible_in,      // Wrong card
  input  wire             option_connector_bad_in,     // Link bad
  input  wire             option_selftest_err_in,      // HW error
  input  wire             option_flash_mode_in,        // Flashing
  input  wire             option_link_up_in,           // Comm alive
  input  wire             run_source_option_in,        // Run on opt
  input  wire             ref_source_option_in,        // Ref on opt
  // Decoded commands
  output reg              run_out,          // Motor run request
  output reg              reverse_out,      // Reverse direction
  output reg              network_external_fault_out,  // Ext fault
  output reg              fault_reset_out,  // Fault reset pulse
  output reg  [6:0]       mf_inputs_out,    // Inputs 1 to 7
  output reg              network_reference_select_out, // Ref sel
  output reg              network_control_select_out,   // Ctl sel
  output reg  [15:0]      speed_reference_out,  // Reference value
  output reg  [2:0]       speed_unit_out,   // Its unit code
  output reg  [15:0]      volts_per_hertz_gain_out, // Used gain
  output reg              gain_active_out,  // Register gain used
  output reg  signed [15:0] loop_setpoint_out, // 0.01 % steps
  output wire [DAC_W-1:0] analog_output_code_out, // DAC code
  output wire [3:0]       option_fault_flags_out, // 00,01,03,04
  output wire [7:0]       option_fault_code_out,  // Top code
  output wire             option_fault_out, // Any option fault
  output wire             comm_loss_fault_out // Option link lost
);

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------

  // True when the address names a stored command word
  function is_cmd_word;
    input [15:0] addr;
    begin
      is_cmd_word = (addr == `DCRB_ADDR_OPER)  ||
                    (addr == `DCRB_ADDR_SPEED) ||
                    (addr == `DCRB_ADDR_GAIN)  ||
                    (addr == `DCRB_ADDR_SETPT) ||
                    (addr == `DCRB_ADDR_AOUT);
    end
  endfunction

  // ------------------------------------------------------------
  // Command storage
  // ------------------------------------------------------------
  reg  [15:0] oper_word;                  // Operation and inputs
  reg  [15:0] speed_word;                 // Speed reference
  reg  [15:0] gain_word;                  // Volts per hertz gain
  reg  [15:0] setpt_word;                 // Loop setpoint
  reg  [15:0] aout_word;                  // Analog output level
  reg         frst_prev;                  // Last fault reset bit

  wire        wr_oper;                    // Write to operation
  wire        wr_speed;                   // Write to speed
  wire        wr_gain;                    // Write to gain
  wire        wr_setpt;                   // Write to setpoint
  wire        wr_aout;                    // Write to analog level
  wire [15:0] next_oper;                  // Masked operation word

  assign wr_oper  = reg_wr_in & (reg_addr_in == `DCRB_ADDR_OPER);
  assign wr_speed = reg_wr_in & (reg_addr_in == `DCRB_ADDR_SPEED);
  assign wr_gain  = reg_wr_in & (reg_addr_in == `DCRB_ADDR_GAIN);
  assign wr_setpt = reg_wr_in & (reg_addr_in == `DCRB_ADDR_SETPT);
  assign wr_aout  = reg_wr_in & (reg_addr_in == `DCRB_ADDR_AOUT);

  // Unused bits dropped so a careless master cannot set them
  assign next_oper = reg_wdata_in & `DCRB_OPER_MASK;

  // Word-wide writes; reserved words have no storage
  always @(posedge mclk_in) begin
    if (srst_in) begin
      oper_word  <= `DCRB_RST_OPER;
      speed_word <= `DCRB_RST_SPEED;
      gain_word  <= `DCRB_RST_GAIN;
      setpt_word <= `DCRB_RST_SETPT;
      aout_word  <= `DCRB_RST_AOUT;
    end else begin
      if (wr_oper) begin
        oper_word <= next_oper;
      end
      if (wr_speed) begin
        speed_word <= reg_wdata_in;
      end
      if (wr_gain) begin
        gain_word <= reg_wdata_in;
      end
      if (wr_setpt) begin
        setpt_word <= reg_wdata_in;
      end
      if (wr_aout) begin
        aout_word <= reg_wdata_in;
      end
    end
  end

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------

  // One-cycle answer; unknown or reserved words read zero
  always @(posedge mclk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 16'h0000;
      reg_ack_out   <= 1'b0;
    end else begin
      reg_ack_out <= reg_wr_in | reg_rd_in;
      if (reg_rd_in && is_cmd_word(reg_addr_in)) begin
        case (reg_addr_in)
          `DCRB_ADDR_OPER:  reg_rdata_out <= oper_word;
          `DCRB_ADDR_SPEED: reg_rdata_out <= speed_word;
          `DCRB_ADDR_GAIN:  reg_rdata_out <= gain_word;
          `DCRB_ADDR_SETPT: reg_rdata_out <= setpt_word;
          `DCRB_ADDR_AOUT:  reg_rdata_out <= aout_word;
          default:          reg_rdata_out <= 16'h0000;
        endcase
      end else if (reg_rd_in) begin
        // Reserved or unmapped: zero, no side effect
        reg_rdata_out <= 16'h0000;
      end
    end
  end

  // ------------------------------------------------------------
  // Run and direction decode
  // ------------------------------------------------------------
  reg next_run;                           // Decoded run
  reg next_rev;                           // Decoded direction

  // Style 0 treats both bits set as stop, the safe reading
  always @* begin
    next_run = 1'b0;
    next_rev = 1'b0;
    if (run_command_style_select_in) begin
      next_run = oper_word[`DCRB_BIT_RUN0];
      next_rev = oper_word[`DCRB_BIT_RUN1];
    end else begin
      // Forward only, reverse only, or stop
      next_run = oper_word[`DCRB_BIT_RUN0] ^
                 oper_word[`DCRB_BIT_RUN1];
      next_rev = oper_word[`DCRB_BIT_RUN1] &
                 ~oper_word[`DCRB_BIT_RUN0];
    end
  end

  // ------------------------------------------------------------
  // Command outputs
  // ------------------------------------------------------------

  // Registered command outputs, one cycle behind the words
  always @(posedge mclk_in) begin
    if (srst_in) begin
      run_out                      <= 1'b0;
      reverse_out                  <= 1'b0;
      network_external_fault_out   <= 1'b0;
      fault_reset_out              <= 1'b0;
      frst_prev                    <= 1'b0;
      mf_inputs_out                <= 7'h00;
      network_reference_select_out <= 1'b0;
      network_control_select_out   <= 1'b0;
    end else begin
      run_out     <= next_run;
      reverse_out <= next_rev;
      // Fault follows the bit; the master clears by resetting it
      network_external_fault_out <= oper_word[`DCRB_BIT_EXTF];
      // Reset acts on the rising edge only, never held
      frst_prev       <= oper_word[`DCRB_BIT_FRST];
      fault_reset_out <= oper_word[`DCRB_BIT_FRST] & ~frst_prev;
      mf_inputs_out <=
        oper_word[`DCRB_BIT_MF_HI:`DCRB_BIT_MF_LO];
      network_reference_select_out <=
        (input1_function_select_in == `DCRB_FN_NET_REF) &
        oper_word[`DCRB_BIT_MF_LO];
      network_control_select_out <=
        (input2_function_select_in == `DCRB_FN_NET_CTRL) &
        oper_word[`DCRB_BIT_MF_LO+1];
    end
  end

  // ------------------------------------------------------------
  // Reference, gain and setpoint outputs
  // ------------------------------------------------------------

  // Unit code travels with the value so the consumer scales it
  always @(posedge mclk_in) begin
    if (srst_in) begin
      speed_reference_out      <= `DCRB_RST_SPEED;
      speed_unit_out           <= 3'h0;
      volts_per_hertz_gain_out <= UNITY_GAIN;
      gain_active_out          <= 1'b0;
      loop_setpoint_out        <= `DCRB_RST_SETPT;
    end else begin
      speed_reference_out <= speed_word;
      speed_unit_out      <= speed_unit_select_in;
      gain_active_out     <= vf_control_mode_in;
      if (vf_control_mode_in) begin
        volts_per_hertz_gain_out <= gain_word;
      end else begin
        // Other control modes must not see the written gain
        volts_per_hertz_gain_out <= UNITY_GAIN;
      end
      loop_setpoint_out <= $signed(setpt_word);
    end
  end

  // ------------------------------------------------------------
  // Analog output and option fault logic
  // ------------------------------------------------------------
  wire link_owned;                        // Option owns control

  assign link_owned = run_source_option_in &
                      ref_source_option_in;

  // Linear DAC code for the analog output terminal
  dcrb_analog_scale #(
    .DAC_W    (DAC_W)
  ) u_scale (
    .mclk_in  (mclk_in),
    .srst_in  (srst_in),
    .level_in (aout_word),
    .code_out (analog_output_code_out)
  );

  // Option faults cleared by the same fault reset pulse
  dcrb_fault_monitor u_faults (
    .mclk_in       (mclk_in),
    .srst_in       (srst_in),
    .incompat_in   (option_incompatible_in),
    .connector_in  (option_connector_bad_in),
    .selftest_in   (option_selftest_err_in),
    .flash_mode_in (option_flash_mode_in),
    .link_up_in    (option_link_up_in),
    .assigned_in   (link_owned),
    .clear_in      (fault_reset_out),
    .flags_out     (option_fault_flags_out),
    .loss_out      (comm_loss_fault_out),
    .code_out      (option_fault_code_out),
    .any_out       (option_fault_out)
  );

endmodule // dcrb_command_bank

// >>> testbench/dcrb_command_bank_properties.sv
// Purpose: Port properties of the command register bank
// Assumes: One clock, sync active-high reset
// Notes:   Bound to the bank by the statement at the foot
`timescale 1ns/100ps
module dcrb_command_bank_properties (
  input wire        mclk_in,                     // Clock
  input wire        srst_in,                     // Reset
  input wire [15:0] reg_addr_in,                 // Address
  input wire        reg_wr_in,                   // Write
  input wire        reg_rd_in,                   // Read
  input wire [15:0] reg_wdata_in,                // Data
  input wire        reg_ack_out,                 // Done
  input wire        run_command_style_select_in, // Style
  input wire        option_incompatible_in,      // Wrong card
  input wire        run_out,                     // Run
  input wire        reverse_out,                 // Reverse
  input wire        network_external_fault_out,  // Ext fault
  input wire [6:0]  mf_inputs_out,               // Inputs
  input wire        fault_reset_out,             // Reset pulse
  input wire [3:0]  option_fault_flags_out       // Faults
);
  // ------------------------------------
  // Helpers
  // ------------------------------------
  wire req = reg_wr_in || reg_rd_in;               // Any access
  wire opw = reg_wr_in && reg_addr_in == 16'h0001; // Op write
  wire sty = run_command_style_select_in;          // Style alias
  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // Ack one cycle after each strobe, never without one
  AST_ACK_AFTER_REQ: assert property (req |=> reg_ack_out)
    else $error("No ack after strobe");
  AST_NO_ACK_IDLE: assert property (!req |=> !reg_ack_out)
    else $error("Ack without strobe");
  // Decoded run outputs trail the stored word by one cycle
  AST_STYLE0_FWD: assert property (
    opw && reg_wdata_in[1:0] == 2'h1 && !sty ##1 !sty
    |=> run_out && !reverse_out) else $error("Forward run wrong");
  AST_STYLE0_REV: assert property (
    opw && reg_wdata_in[1:0] == 2'h2 && !sty ##1 !sty
    |=> reverse_out && !run_out) else $error("Reverse run wrong");
  AST_STYLE1_RUN_DIR: assert property (
    opw && sty ##1 sty |=> run_out == $past(reg_wdata_in[0], 2)
    && reverse_out == $past(reg_wdata_in[1], 2))
    else $error("Run or direction wrong");
  // Level outputs, not latched: follow the word exactly
  AST_EXT_FAULT: assert property (opw |=> ##1
    network_external_fault_out == $past(reg_wdata_in[2], 2))
    else $error("External fault wrong");
  AST_MF_INPUTS: assert property (opw |=> ##1
    mf_inputs_out == $past(reg_wdata_in[10:4], 2))
    else $error("Input bits wrong");
  // Set wins over clear, so a cause always lands
  AST_INCOMPAT_FLAG: assert property (
    option_incompatible_in |=> option_fault_flags_out[0])
    else $error("Incompatible card not flagged");
  // Fault reset acts on an edge of the bit, never held high
  AST_FRST_PULSE: assert property (
    fault_reset_out |=> !fault_reset_out) else $error("Fault reset held");
  cover property (opw && sty);
  cover property (opw && reg_wdata_in[2]);
  cover property (option_incompatible_in);
endmodule // dcrb_command_bank_properties

bind dcrb_command_bank dcrb_command_bank_properties u_props (.*);

// >>> testbench/dcrb_ctrl_model.sv
// Purpose: Upper controller model on the command register port
// Assumes: One strobe cycle per access, ack one cycle later
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/100ps
module dcrb_ctrl_model (
  input  wire        mclk_in,                   // Clock
  input  wire        reg_ack_out,               // Done
  input  wire [15:0] reg_rdata_out,             // Read data
  output reg  [15:0] reg_addr_in  = 16'h0000,   // Address
  output reg         reg_wr_in    = 1'b0,       // Write
  output reg         reg_rd_in    = 1'b0,       // Read
  output reg  [15:0] reg_wdata_in = 16'h0000    // Data
);
  // One word access, entered just after a rising edge
  task xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
            output logic [15:0] q);
    integer n;
    begin
      reg_addr_in = a;
      reg_wdata_in = (a == 16'h0001) ? d & 16'h07FF : d;
      reg_wr_in = w;
      reg_rd_in = !w;
      @(posedge mclk_in);
      #1;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      n = 0;
      // Bounded wait, a dead port must not hang us
      while (reg_ack_out !== 1'b1 && n < 8) begin
        @(posedge mclk_in);
        #1;
        n = n + 1;
      end
      q = (n < 8) ? reg_rdata_out : 16'hXXXX;
      reg_addr_in = ~a;              // No stale address
      reg_wdata_in = ~reg_wdata_in;  // No stale data
      // Strobes stay low across one edge before the next access
      @(posedge mclk_in);
      #1;
    end
  endtask
endmodule // dcrb_ctrl_model

// >>> testbench/dcrb_command_bank_tb.sv
// Purpose: Self-checking bench of the command register bank
// Assumes: Inputs move 1 ns after the rising edge
// Notes:   Expected words kept in an integer image array
`timescale 1ns/100ps
module dcrb_command_bank_tb;
  logic        mclk_in = 1'b0, srst_in = 1'b1;     // Clock, reset
  logic        run_command_style_select_in = 1'b0; // Style
  logic [7:0]  input1_function_select_in = 8'h00;  // Input 1 fn
  logic [7:0]  input2_function_select_in = 8'h00;  // Input 2 fn
  logic [2:0]  speed_unit_select_in = 3'h0;        // Units
  logic        vf_control_mode_in = 1'b0;          // V/f mode
  logic        option_incompatible_in = 1'b0, option_connector_bad_in = 1'b0;
  logic        option_selftest_err_in = 1'b0, option_flash_mode_in = 1'b0;
  logic        option_link_up_in = 1'b0, run_source_option_in = 1'b0;
  logic        ref_source_option_in = 1'b0;        // Ownership
  wire  [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  wire         reg_wr_in, reg_rd_in, reg_ack_out, run_out, reverse_out;
  wire         network_external_fault_out, fault_reset_out;
  wire         network_reference_select_out, network_control_select_out;
  wire  [6:0]  mf_inputs_out;
  wire  [15:0] speed_reference_out, volts_per_hertz_gain_out;
  wire  [2:0]  speed_unit_out;
  wire         gain_active_out, option_fault_out, comm_loss_fault_out;
  wire signed [15:0] loop_setpoint_out;
  wire  [11:0] analog_output_code_out;
  wire  [3:0]  option_fault_flags_out;
  wire  [7:0]  option_fault_code_out;
  integer      failures = 0, n_compared = 0;       // Tallies
  integer      mem [0:9];                          // Expected words
  integer      i, k;                               // Indices
  logic [31:0] lfsr = 32'h0000F7BE;                // Random state
  logic [15:0] a, q;                               // Address, word

  dcrb_command_bank #(.DAC_W(12), .UNITY_GAIN(16'h0064)) uut (.*);
  dcrb_ctrl_model ctrl (.*);
  always #2.5 mclk_in = ~mclk_in; // 200 MHz

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  // Clamp low below zero, clamp high from 4000 hex upward
  function automatic integer aout(input integer lv);
    if (lv[15]) aout = 0;
    else if (lv >= 32'h4000) aout = 32'hFFF;
    else aout = (lv * 32'hFFF) >> 14;
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task step(input integer n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // Write and track; reserved and unmapped words keep zero
  task wr(input logic [15:0] ad, input logic [15:0] d);
    ctrl.xfer(1'b1, ad, d, q);
    if (ad inside {16'h1, 16'h2, 16'h3, 16'h6, 16'h7})
      mem[ad] = (ad == 16'h1) ? d & 16'h07FF : d;
  endtask
  task fault_clear;
    wr(16'h0001, 16'h0000); // Bit 3 low first, so a rising edge follows
    wr(16'h0001, 16'h0008);
    wr(16'h0001, 16'h0000);
  endtask
  // Every decoded output but fault_reset_out and the option fault and link loss outputs against the word images
  task check_outputs;
    logic [15:0] op;
    op = mem[1];
    if (run_command_style_select_in) begin
      check(run_out, op[0]);
      check(reverse_out, op[1]);
    end else begin
      check(run_out, op[0] ^ op[1]);
      check(reverse_out, op[1] & ~op[0]);
    end
    check(network_external_fault_out, op[2]);
    check(mf_inputs_out, op[10:4]);
    check(network_reference_select_out,
          op[4] && input1_function_select_in == 8'h28);
    check(network_control_select_out,
          op[5] && input2_function_select_in == 8'h29);
    check(speed_reference_out, mem[2]);
    check(speed_unit_out, speed_unit_select_in);
    check(volts_per_hertz_gain_out,
          vf_control_mode_in ? mem[3] : 32'h64);
    check(gain_active_out, vf_control_mode_in);
    check($unsigned(loop_setpoint_out), mem[6]);
    check(analog_output_code_out, aout(mem[7]));
  endtask

  // Main sequence: reset reads, random traffic, faults, link loss
  initial begin
    for (i = 0; i < 10; i++) mem[i] = 0;
    step(10);
    srst_in = 1'b0;
    check_outputs;
    for (i = 0; i < 210; i++) begin
      lfsr = next_rand(lfsr);
      {vf_control_mode_in, run_command_style_select_in} = lfsr[1:0];
      input1_function_select_in = lfsr[2] ? 8'h28 : lfsr[15:8];
      input2_function_select_in = lfsr[3] ? 8'h29 : lfsr[23:16];
      speed_unit_select_in = lfsr[6:4];
      a = (i < 10) ? i[15:0] : {12'h000, lfsr[27:24] % 4'hA};
      lfsr = next_rand(lfsr);
      if (i >= 10) wr(a, lfsr[15:0]);
      ctrl.xfer(1'b0, a, 16'h0000, q);
      check(q, mem[a]);
      check_outputs;
    end
    // One card cause at a time, latched then cleared
    for (k = 0; k < 4; k++) begin
      {option_flash_mode_in, option_selftest_err_in,
       option_connector_bad_in, option_incompatible_in} = 4'h1 << k;
      step(1);
      {option_flash_mode_in, option_selftest_err_in,
       option_connector_bad_in, option_incompatible_in} = 4'h0;
      step(2);
      check(option_fault_flags_out, 32'h1 << k);
      check(option_fault_code_out, (k < 2) ? k : k + 1);
      check(option_fault_out, 1'b1);
      fault_clear;
      check(option_fault_flags_out, 32'h0);
    end
    // Link loss counts only while the option owns run and reference
    {option_link_up_in, run_source_option_in, ref_source_option_in} = 3'h7;
    step(1);
    option_link_up_in = 1'b0;
    step(3);
    check(comm_loss_fault_out, 1'b1);
    option_link_up_in = 1'b1;
    run_source_option_in = 1'b0;
    fault_clear;
    option_link_up_in = 1'b0;
    step(3);
    check(comm_loss_fault_out, 1'b0);
    end_sim;
  end
  // Watchdog, well beyond the expected run length
  initial begin
    #20000;
    failures = failures + 1;
    end_sim;
  end
endmodule // dcrb_command_bank_tb
